// [src/switch_buffer_drop_stats.sv]
// Buffer manager drop counters, init status and random discard table behind classic Wishbone
`timescale 1ns/100ps
module switch_buffer_drop_stats #(
	parameter int INIT_ENTRIES = 256
) (
	input  wire logic                                clk_i,
	input  wire logic                                rst_i,
	input  wire logic                                ce_i,
	input  wire logic                                wb_cyc_i,
	input  wire logic                                wb_stb_i,
	input  wire logic                                wb_we_i,
	input  wire logic [drop_stats_pkg::ADDR_W-1:0]   wb_adr_i,
	input  wire logic [3:0]                          wb_sel_i,
	input  wire logic [drop_stats_pkg::DATA_W-1:0]   wb_dat_i,
	output logic      [drop_stats_pkg::DATA_W-1:0]   wb_dat_o,
	output logic                                     wb_ack_o,
	input  wire logic                                pkt_valid_i,
	input  wire drop_stats_pkg::pkt_req_t            pkt_i,
	output logic                                     pkt_done_o,
	output logic                                     pkt_drop_o,
	output logic                                     ready_o
);

	localparam int INIT_W = $clog2(INIT_ENTRIES + 1);
	localparam logic [INIT_W-1:0] INIT_LAST = INIT_W'(INIT_ENTRIES - 1);

	typedef enum logic {
		ST_INIT,
		ST_READY
	} init_state_t;

	// One register decode shared by every strobe; byte-wide fields also need their lane
	function automatic logic reg_sel(input logic [drop_stats_pkg::IDX_W-1:0] at_idx,
		input logic [drop_stats_pkg::IDX_W-1:0] reg_idx, input logic lane);
		reg_sel = at_idx == reg_idx && lane;
	endfunction

	init_state_t                              state_q;
	logic [INIT_W-1:0]                        init_cnt_q;
	logic [drop_stats_pkg::CFG_W-1:0]         cfg_q;
	logic [drop_stats_pkg::CMD_W-1:0]         cmd_q;
	logic [drop_stats_pkg::PROB_W-1:0]        wdata_q;
	logic [drop_stats_pkg::PROB_W-1:0]        rdata_q;
	logic [drop_stats_pkg::LFSR_W-1:0]        lfsr_q;
	logic [drop_stats_pkg::DATA_W-1:0]        rd_d;
	logic [drop_stats_pkg::IDX_W-1:0]         idx;
	logic                                     req;
	logic                                     wr;
	logic                                     rd;
	logic                                     cmd_wr;
	logic                                     tbl_we;
	logic [drop_stats_pkg::PROB_W-1:0]        tbl_host_data;
	logic [drop_stats_pkg::PROB_W-1:0]        tbl_pkt_prob;
	logic [drop_stats_pkg::TBL_IDX_W-1:0]     pkt_entry;
	logic                                     drop_now;
	logic                                     lfsr_fb;
	logic [drop_stats_pkg::NUM_PORTS-1:0]     inc;
	logic [drop_stats_pkg::NUM_PORTS-1:0]     clr;
	logic [drop_stats_pkg::DATA_W-1:0]        count [drop_stats_pkg::NUM_PORTS];
	logic                                     cfg_wr;
	logic                                     wdata_wr;
	logic                                     tbl_re;
	logic                                     space_drop;
	logic                                     red_drop;
	logic                                     yellow_drop;

	// Bus decode: one new request per cycle in which ack is not already high
	assign req    = wb_cyc_i && wb_stb_i && !wb_ack_o;
	assign wr     = req && wb_we_i;
	assign rd     = req && !wb_we_i;
	assign idx    = wb_adr_i[drop_stats_pkg::ADDR_W-1:2];
	assign cmd_wr   = wr && reg_sel(idx, drop_stats_pkg::IDX_CMD, wb_sel_i[0]);
	assign cfg_wr   = wr && reg_sel(idx, drop_stats_pkg::IDX_CONFIG, wb_sel_i[0]);
	assign wdata_wr = wr && reg_sel(idx, drop_stats_pkg::IDX_WDATA, 1'b1);
	assign tbl_re   = cmd_wr && wb_dat_i[drop_stats_pkg::CMD_DIR_BIT];

	// Initialisation walk over the buffer manager tables after each reset
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			init_cnt_q <= '0;
		end else if (ce_i && state_q == ST_INIT && init_cnt_q != INIT_LAST) begin
			init_cnt_q <= init_cnt_q + 1'b1;
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			state_q <= ST_INIT;
		end else if (ce_i) begin
			unique case (state_q)
				ST_INIT: begin
					if (init_cnt_q == INIT_LAST) begin
						state_q <= ST_READY;
					end
				end
				ST_READY: begin
					state_q <= ST_READY;
				end
			endcase
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			ready_o <= 1'b0;
		end else if (ce_i) begin
			ready_o <= state_q == ST_READY;
		end
	end

	// Configuration: drop on red, drop on yellow, counter test
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			cfg_q <= drop_stats_pkg::CFG_RESET;
		end else if (ce_i && cfg_wr) begin
			cfg_q <= wb_dat_i[drop_stats_pkg::CFG_W-1:0] & drop_stats_pkg::CFG_MASK;
		end
	end

	// Write data holding register, filled by byte lanes
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			wdata_q <= drop_stats_pkg::PROB_RESET;
		end else if (ce_i && wdata_wr) begin
			if (wb_sel_i[0]) begin
				wdata_q[7:0] <= wb_dat_i[7:0];
			end
			if (wb_sel_i[1]) begin
				wdata_q[9:8] <= wb_dat_i[9:8];
			end
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			cmd_q <= drop_stats_pkg::CMD_RESET;
		end else if (ce_i && cmd_wr) begin
			cmd_q <= wb_dat_i[drop_stats_pkg::CMD_W-1:0];
		end
	end

	// Table access: a write command stores the held write data at the entry
	assign tbl_we = cmd_wr && !wb_dat_i[drop_stats_pkg::CMD_DIR_BIT];

	discard_table #(
		.DEPTH (drop_stats_pkg::TABLE_DEPTH),
		.WIDTH (drop_stats_pkg::PROB_W),
		.AW    (drop_stats_pkg::TBL_IDX_W)
	) u_table (
		.clk_i     (clk_i),
		.ce_i      (ce_i),
		.we_i      (tbl_we),
		.waddr_i   (wb_dat_i[drop_stats_pkg::TBL_IDX_W-1:0]),
		.wdata_i   (wdata_q),
		.raddr_a_i (wb_dat_i[drop_stats_pkg::TBL_IDX_W-1:0]),
		.rdata_a_o (tbl_host_data),
		.raddr_b_i (pkt_entry),
		.rdata_b_o (tbl_pkt_prob)
	);

	// A read command captures the entry so the data register can be read later
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			rdata_q <= drop_stats_pkg::PROB_RESET;
		end else if (ce_i && tbl_re) begin
			rdata_q <= tbl_host_data;
		end
	end

	// Free-running pseudo-random source for yellow discards
	assign lfsr_fb = lfsr_q[15] ^ lfsr_q[13] ^ lfsr_q[12] ^ lfsr_q[10];

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			lfsr_q <= drop_stats_pkg::LFSR_SEED;
		end else if (ce_i) begin
			lfsr_q <= {lfsr_q[drop_stats_pkg::LFSR_W-2:0], lfsr_fb};
		end
	end

	// Drop decision; space limit always drops, colours only when enabled
	assign pkt_entry = drop_stats_pkg::usage_to_index(pkt_i.usage);

	assign space_drop  = pkt_i.space_full;
	assign red_drop    = pkt_i.color == drop_stats_pkg::COLOR_RED && cfg_q[drop_stats_pkg::CFG_RED_BIT];
	// Uniform 10-bit draw below the entry gives entry/1024 probability
	assign yellow_drop = pkt_i.color == drop_stats_pkg::COLOR_YELLOW && cfg_q[drop_stats_pkg::CFG_YELLOW_BIT]
		&& lfsr_q[drop_stats_pkg::PROB_W-1:0] < tbl_pkt_prob;

	always_comb begin
		drop_now = 1'b0;
		if (space_drop || red_drop || yellow_drop) begin
			drop_now = 1'b1;
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			pkt_done_o <= 1'b0;
		end else if (ce_i) begin
			pkt_done_o <= pkt_valid_i;
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			pkt_drop_o <= 1'b0;
		end else if (ce_i) begin
			pkt_drop_o <= pkt_valid_i && drop_now;
		end
	end

	// Per-port counters; an illegal port number counts nowhere
	for (genvar p = 0; p < drop_stats_pkg::NUM_PORTS; p++) begin : g_port
		assign inc[p] = pkt_valid_i && drop_now && pkt_i.port == drop_stats_pkg::PORT_W'(p);
		assign clr[p] = rd && reg_sel(idx, drop_stats_pkg::IDX_CNT0 + drop_stats_pkg::IDX_W'(p), 1'b1);

		drop_counter #(
			.WIDTH (drop_stats_pkg::DATA_W)
		) u_cnt (
			.clk_i   (clk_i),
			.rst_i   (rst_i),
			.ce_i    (ce_i),
			.inc_i   (inc[p]),
			.clr_i   (clr[p]),
			.test_i  (cfg_q[drop_stats_pkg::CFG_TEST_BIT]),
			.count_o (count[p])
		);
	end

	// Read mux; unmapped and reserved bits answer zero
	always_comb begin
		rd_d = '0;
		unique case (idx)
			drop_stats_pkg::IDX_CONFIG: begin
				rd_d[drop_stats_pkg::CFG_W-1:0] = cfg_q;
			end
			drop_stats_pkg::IDX_CNT0: begin
				rd_d = count[0];
			end
			drop_stats_pkg::IDX_CNT1: begin
				rd_d = count[1];
			end
			drop_stats_pkg::IDX_CNT2: begin
				rd_d = count[2];
			end
			drop_stats_pkg::IDX_STATUS: begin
				rd_d[drop_stats_pkg::STATUS_RDY_BIT] = ready_o;
			end
			drop_stats_pkg::IDX_CMD: begin
				rd_d[drop_stats_pkg::CMD_W-1:0] = cmd_q;
			end
			drop_stats_pkg::IDX_WDATA: begin
				rd_d[drop_stats_pkg::PROB_W-1:0] = wdata_q;
			end
			drop_stats_pkg::IDX_RDATA: begin
				rd_d[drop_stats_pkg::PROB_W-1:0] = rdata_q;
			end
			default: begin
				rd_d = '0;
			end
		endcase
	end

	// Ack one cycle after the request, dropped in the following cycle
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			wb_ack_o <= 1'b0;
		end else if (ce_i) begin
			wb_ack_o <= req;
		end
	end

	// Read data is held after the ack so the master may take it at its own pace
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			wb_dat_o <= '0;
		end else if (ce_i && rd) begin
			wb_dat_o <= rd_d;
		end
	end

endmodule

// [src/drop_stats_pkg.sv]
// Shared constants, types and helpers of the buffer manager drop statistics block
// Functional notes
// - One dropped-packet counter each for ingress ports 0, 1 and 2.
// - Counted drops: buffer space limit, red discard, random yellow discard.
// - Reading a counter returns its 32-bit value then clears it; zero after reset.
// - Counters saturate at all ones instead of wrapping.
// - Buffer manager tables are initialised after every fabric reset.
// - Ready flag bit 0 reads 0 after reset, sets once initialisation completes.
// - Every write to the command register with byte lane 0 selected performs one table access.
// - Command bit 4 selects access: 1 reads the table, 0 writes it.
// - A read command loads the addressed entry into the read-data register.
// - Sixteen probability entries, selected by command bits 3:0.
// - Entry ranges: 8 buffers below 64, 16 below 128, 32 below 256.
// - The entry chosen by the port's buffer usage is the drop probability.
// - Entries are 10-bit yellow discard probabilities in 1/1024 units.
// - Table is not initialised at reset; software fills all entries first.
// - With counter test set, a read loads 7fff_fffc instead of zero.
package drop_stats_pkg;

	localparam int ADDR_W      = 16;
	localparam int DATA_W      = 32;
	localparam int IDX_W       = 14;
	localparam int NUM_PORTS   = 3;
	localparam int PORT_W      = 2;
	localparam int USAGE_W     = 8;
	localparam int PROB_W      = 10;
	localparam int TBL_IDX_W   = 4;
	localparam int TABLE_DEPTH = 16;
	localparam int CFG_W       = 7;
	localparam int CMD_W       = 5;
	localparam int LFSR_W      = 16;

	// Register indexes; the byte address is four times the index
	localparam logic [IDX_W-1:0] IDX_CONFIG  = 14'h1c00;
	localparam logic [IDX_W-1:0] IDX_CNT0    = 14'h1c05;
	localparam logic [IDX_W-1:0] IDX_CNT1    = 14'h1c06;
	localparam logic [IDX_W-1:0] IDX_CNT2    = 14'h1c07;
	localparam logic [IDX_W-1:0] IDX_STATUS  = 14'h1c08;
	localparam logic [IDX_W-1:0] IDX_CMD     = 14'h1c09;
	localparam logic [IDX_W-1:0] IDX_WDATA   = 14'h1c0a;
	localparam logic [IDX_W-1:0] IDX_RDATA   = 14'h1c0b;

	localparam int CFG_RED_BIT    = 0;
	localparam int CFG_YELLOW_BIT = 1;
	localparam int CFG_TEST_BIT   = 6;
	localparam int CMD_DIR_BIT    = 4;
	localparam int STATUS_RDY_BIT = 0;

	localparam logic [CFG_W-1:0]  CFG_RESET  = 7'h00;
	localparam logic [CFG_W-1:0]  CFG_MASK   = 7'h43;
	localparam logic [CMD_W-1:0]  CMD_RESET  = 5'h00;
	localparam logic [PROB_W-1:0] PROB_RESET = 10'h000;

	localparam logic [DATA_W-1:0] CNT_RESET      = 32'h00000000;
	localparam logic [DATA_W-1:0] CNT_TEST_VALUE = 32'h7ffffffc;
	localparam logic [DATA_W-1:0] CNT_MAX        = 32'hffffffff;

	localparam logic [USAGE_W-1:0]   USAGE_FINE_END = 8'h40;
	localparam logic [USAGE_W-1:0]   USAGE_MID_END  = 8'h80;
	localparam logic [TBL_IDX_W-1:0] MID_BASE       = 4'h8;
	localparam logic [TBL_IDX_W-1:0] COARSE_BASE    = 4'hc;

	localparam logic [LFSR_W-1:0] LFSR_SEED = 16'hace1;

	typedef enum logic [1:0] {
		COLOR_GREEN,
		COLOR_YELLOW,
		COLOR_RED
	} color_t;

	typedef struct packed {
		logic [PORT_W-1:0]  port;
		color_t             color;
		logic [USAGE_W-1:0] usage;
		logic               space_full;
	} pkt_req_t;

	// Buffer usage to table entry: finer steps at low usage
	function automatic logic [TBL_IDX_W-1:0] usage_to_index(input logic [USAGE_W-1:0] usage);
		if (usage < USAGE_FINE_END) begin
			usage_to_index = {1'b0, usage[5:3]};
		end else if (usage < USAGE_MID_END) begin
			usage_to_index = MID_BASE | {2'b00, usage[5:4]};
		end else begin
			usage_to_index = COARSE_BASE | {2'b00, usage[6:5]};
		end
	endfunction

endpackage

// [src/drop_counter.sv]
// Saturating clear-on-read packet drop counter
`timescale 1ns/100ps
module drop_counter #(
	parameter int WIDTH = drop_stats_pkg::DATA_W
) (
	input  wire logic             clk_i,
	input  wire logic             rst_i,
	input  wire logic             ce_i,
	input  wire logic             inc_i,
	input  wire logic             clr_i,
	input  wire logic             test_i,
	output logic      [WIDTH-1:0] count_o
);

	logic [WIDTH-1:0] base;
	logic [WIDTH-1:0] all_ones;

	assign all_ones = '1;
	assign base = test_i ? WIDTH'(drop_stats_pkg::CNT_TEST_VALUE) : WIDTH'(drop_stats_pkg::CNT_RESET);

	// A drop in the same cycle as the clearing read is kept, not lost
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			count_o <= WIDTH'(drop_stats_pkg::CNT_RESET);
		end else if (ce_i) begin
			if (clr_i) begin
				count_o <= base + WIDTH'(inc_i);
			end else if (inc_i && count_o != all_ones) begin
				count_o <= count_o + 1'b1;
			end
		end
	end

endmodule

// [src/discard_table.sv]
// Sixteen-entry random discard probability table, one write and two read ports
`timescale 1ns/100ps
module discard_table #(
	parameter int DEPTH  = drop_stats_pkg::TABLE_DEPTH,
	parameter int WIDTH  = drop_stats_pkg::PROB_W,
	parameter int AW     = drop_stats_pkg::TBL_IDX_W
) (
	input  wire logic             clk_i,
	input  wire logic             ce_i,
	input  wire logic             we_i,
	input  wire logic [AW-1:0]    waddr_i,
	input  wire logic [WIDTH-1:0] wdata_i,
	input  wire logic [AW-1:0]    raddr_a_i,
	output logic      [WIDTH-1:0] rdata_a_o,
	input  wire logic [AW-1:0]    raddr_b_i,
	output logic      [WIDTH-1:0] rdata_b_o
);

	// No reset: contents are undefined until software fills every entry
	logic [WIDTH-1:0] mem [DEPTH];

	always_ff @(posedge clk_i) begin
		if (ce_i && we_i) begin
			mem[waddr_i] <= wdata_i;
		end
	end

	assign rdata_a_o = mem[raddr_a_i];
	assign rdata_b_o = mem[raddr_b_i];

endmodule

// [tb/drop_stats_asserts.sv]
// Port-level assertions of the drop statistics block
`timescale 1ns/100ps
module drop_stats_asserts #(
	parameter int INIT_ENTRIES = 256
) (
	input wire logic                     clk_i,
	input wire logic                     rst_i,
	input wire logic                     ce_i,
	input wire logic                     wb_cyc_i,
	input wire logic                     wb_stb_i,
	input wire logic                     wb_we_i,
	input wire logic [15:0]              wb_adr_i,
	input wire logic [3:0]               wb_sel_i,
	input wire logic [31:0]              wb_dat_i,
	input wire logic [31:0]              wb_dat_o,
	input wire logic                     wb_ack_o,
	input wire logic                     pkt_valid_i,
	input wire drop_stats_pkg::pkt_req_t pkt_i,
	input wire logic                     pkt_done_o,
	input wire logic                     pkt_drop_o,
	input wire logic                     ready_o
);
	logic [15:0] init_cnt_q;
	default clocking cb @(posedge clk_i);
	endclocking
	default disable iff (rst_i);
	// Enabled cycles since reset release, saturating so it never wraps back under the init span
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			init_cnt_q <= 16'h0000;
		end else if (ce_i && init_cnt_q != 16'hffff) begin
			init_cnt_q <= init_cnt_q + 16'h0001;
		end
	end
	sequence s_req;
		wb_cyc_i && wb_stb_i && !wb_ack_o && ce_i;
	endsequence
	sequence s_ack_pulse;
		wb_ack_o ##1 !wb_ack_o;
	endsequence
	AST_ACK_RESP: assert property (s_req |=> s_ack_pulse)
		else $error("bus request not acknowledged with a single pulse");
	AST_ACK_IDLE: assert property (!wb_cyc_i |=> !wb_ack_o)
		else $error("acknowledge without a bus cycle");
	AST_DONE_SET: assert property (pkt_valid_i && ce_i |=> pkt_done_o)
		else $error("packet verdict missing");
	AST_DONE_IDLE: assert property (!pkt_valid_i && ce_i |=> !pkt_done_o)
		else $error("packet verdict without a packet");
	AST_FULL_DROP: assert property (pkt_valid_i && ce_i && pkt_i.space_full |=> pkt_drop_o)
		else $error("packet kept while buffer space full");
	AST_GREEN_KEEP: assert property (pkt_valid_i && ce_i && pkt_i.color == drop_stats_pkg::COLOR_GREEN
		&& !pkt_i.space_full |=> !pkt_drop_o)
		else $error("green packet dropped with space left");
	AST_STATUS_RSVD: assert property (wb_ack_o && !wb_we_i && wb_adr_i[15:2] == drop_stats_pkg::IDX_STATUS
		|-> wb_dat_o[31:1] == 31'h00000000)
		else $error("status reserved bits not zero");
	AST_RDATA_RSVD: assert property (wb_ack_o && !wb_we_i && wb_adr_i[15:2] == drop_stats_pkg::IDX_RDATA
		|-> wb_dat_o[31:10] == 22'h000000)
		else $error("table read data wider than ten bits");
	AST_NOT_READY: assert property (init_cnt_q < INIT_ENTRIES |-> !ready_o)
		else $error("ready before table init finished");
	AST_READY_SET: assert property (init_cnt_q > INIT_ENTRIES + 1 |-> ready_o)
		else $error("ready missing after table init");
endmodule

// [tb/switch_buffer_drop_stats_test.sv]
// Self-checking bench of the drop statistics register block
`timescale 1ns/100ps
module switch_buffer_drop_stats_test;
	localparam int INIT = 4;
	logic                     clk_i = 1'b0;
	logic                     rst_i = 1'b1;
	logic                     ce_i = 1'b1;
	logic                     cyc = 1'b0;
	logic                     stb = 1'b0;
	logic                     we = 1'b0;
	logic [15:0]              adr = 16'h0000;
	logic [3:0]               sel = 4'hf;
	logic [31:0]              wdat = 32'h00000000;
	logic                     pv = 1'b0;
	drop_stats_pkg::pkt_req_t pk = '0;
	logic [31:0]              rdat;
	logic                     ack;
	logic                     done;
	logic                     drop;
	logic                     ready;
	int                       num_errors = 0;
	int                       total_checks = 0;
	always #2 clk_i = ~clk_i;
	switch_buffer_drop_stats #(.INIT_ENTRIES(INIT)) dut (.clk_i(clk_i), .rst_i(rst_i), .ce_i(ce_i),
		.wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat),
		.wb_dat_o(rdat), .wb_ack_o(ack), .pkt_valid_i(pv), .pkt_i(pk), .pkt_done_o(done),
		.pkt_drop_o(drop), .ready_o(ready));
	task automatic finish_test;
		$display("checks %0d errors %0d", total_checks, num_errors);
		if (num_errors == 0 && total_checks > 0) begin
			$display("bench passed");
		end else begin
			$display("bench failed");
		end
		$finish;
	endtask
	task automatic cmp(input string what, input logic [31:0] exp, input logic [31:0] got);
		total_checks++;
		if (got !== exp) begin
			num_errors++;
			$display("unexpected %s expected %h seen %h", what, exp, got);
		end
	endtask
	// Holds the request until the edge that samples ack high, takes the data and releases there
	task automatic bus(input logic w, input logic [13:0] idx, input logic [31:0] d, output logic [31:0] q);
		int n;
		n = 0;
		cyc <= 1'b1;
		stb <= 1'b1;
		we <= w;
		adr <= {idx, 2'b00};
		wdat <= d;
		do begin
			@(posedge clk_i);
			n++;
		end while (ack !== 1'b1);
		cmp("ack latency", 32'h2, 32'(n));
		q = rdat;
		cyc <= 1'b0;
		stb <= 1'b0;
		@(posedge clk_i);
	endtask
	task automatic wr(input logic [13:0] idx, input logic [31:0] d);
		logic [31:0] q;
		bus(1'b1, idx, d, q);
	endtask
	task automatic rd(input logic [13:0] idx, input logic [31:0] exp, input string what);
		logic [31:0] q;
		bus(1'b0, idx, 32'h0, q);
		cmp(what, exp, q);
	endtask
	task automatic ent(input int k, input logic [31:0] v);
		wr(drop_stats_pkg::IDX_WDATA, v);
		wr(drop_stats_pkg::IDX_CMD, 32'(k));
	endtask
	task automatic pkt(input logic [1:0] p, input drop_stats_pkg::color_t c, input logic [7:0] u,
		input logic f, input logic x);
		pv <= 1'b1;
		pk <= '{p, c, u, f};
		@(posedge clk_i);
		pv <= 1'b0;
		@(negedge clk_i);
		cmp("done", 32'h1, {31'h0, done});
		cmp("drop", {31'h0, x}, {31'h0, drop});
		@(posedge clk_i);
	endtask
	task automatic do_reset;
		rst_i <= 1'b1;
		repeat (20) @(posedge clk_i);
		rst_i <= 1'b0;
		@(posedge clk_i);
	endtask
	task automatic t_start;
		int n;
		cmp("ready early", 32'h0, {31'h0, ready});
		rd(drop_stats_pkg::IDX_STATUS, 32'h0, "status early");
		n = 0;
		while (ready !== 1'b1 && n < 50) begin
			@(posedge clk_i);
			n++;
		end
		cmp("ready", 32'h1, {31'h0, ready});
		rd(drop_stats_pkg::IDX_STATUS, 32'h1, "status ready");
		for (int p = 0; p < 3; p++) rd(drop_stats_pkg::IDX_CNT0 + 14'(p), 32'h0, "count reset");
		rd(drop_stats_pkg::IDX_CONFIG, 32'h0, "config reset");
	endtask
	task automatic t_counts;
		for (int p = 0; p < 4; p++)
			for (int i = 0; i <= p; i++) pkt(p[1:0], drop_stats_pkg::COLOR_GREEN, 8'h10, 1'b1, 1'b1);
		pkt(2'd0, drop_stats_pkg::COLOR_GREEN, 8'h10, 1'b0, 1'b0);
		for (int p = 0; p < 3; p++) rd(drop_stats_pkg::IDX_CNT0 + 14'(p), 32'(p + 1), "count");
		for (int p = 0; p < 3; p++) rd(drop_stats_pkg::IDX_CNT0 + 14'(p), 32'h0, "cleared");
	endtask
	task automatic t_reserved;
		wr(drop_stats_pkg::IDX_CONFIG, 32'hffffffff);
		rd(drop_stats_pkg::IDX_CONFIG, 32'h43, "config");
		wr(drop_stats_pkg::IDX_CONFIG, 32'h0);
		wr(drop_stats_pkg::IDX_STATUS, 32'h0);
		rd(drop_stats_pkg::IDX_STATUS, 32'h1, "status");
		wr(drop_stats_pkg::IDX_CNT0, 32'hffffffff);
		rd(drop_stats_pkg::IDX_CNT0, 32'h0, "count write");
		rd(14'h1c0f, 32'h0, "unmapped");
	endtask
	task automatic t_table;
		for (int k = 0; k < 16; k++) begin
			wr(drop_stats_pkg::IDX_WDATA, 32'hfffffc00 | 32'(k * 61 + 3));
			wr(drop_stats_pkg::IDX_CMD, 32'hffffffe0 | 32'(k));
		end
		for (int k = 0; k < 16; k++) begin
			wr(drop_stats_pkg::IDX_CMD, 32'h10 | 32'(k));
			rd(drop_stats_pkg::IDX_RDATA, 32'(k * 61 + 3), "entry");
		end
		for (int k = 0; k < 16; k++) ent(k, 32'h0);
	endtask
	// Port 3 counts nowhere, so the mapping sweep leaves the counters alone
	task automatic t_usage;
		int hi;
		wr(drop_stats_pkg::IDX_CONFIG, 32'h2);
		for (int k = 0; k < 16; k++) begin
			hi = (k < 8) ? 8 * k + 7 : (k < 12) ? 16 * k - 49 : 32 * k - 225;
			ent(k, 32'h3ff);
			pkt(2'd3, drop_stats_pkg::COLOR_YELLOW, 8'(hi), 1'b0, 1'b1);
			if (k < 15) pkt(2'd3, drop_stats_pkg::COLOR_YELLOW, 8'(hi + 1), 1'b0, 1'b0);
			ent(k, 32'h0);
		end
	endtask
	task automatic t_colors;
		wr(drop_stats_pkg::IDX_CONFIG, 32'h0);
		pkt(2'd0, drop_stats_pkg::COLOR_RED, 8'h05, 1'b0, 1'b0);
		wr(drop_stats_pkg::IDX_CONFIG, 32'h3);
		pkt(2'd0, drop_stats_pkg::COLOR_RED, 8'h05, 1'b0, 1'b1);
		pkt(2'd0, drop_stats_pkg::COLOR_YELLOW, 8'h05, 1'b0, 1'b0);
		rd(drop_stats_pkg::IDX_CNT0, 32'h1, "red count");
	endtask
	// Clock enable low: a dropped packet is neither answered nor counted
	task automatic t_freeze;
		ce_i <= 1'b0;
		pv <= 1'b1;
		pk <= '{2'd0, drop_stats_pkg::COLOR_GREEN, 8'h00, 1'b1};
		repeat (3) @(posedge clk_i);
		cmp("frozen done", 32'h0, {31'h0, done});
		cmp("frozen drop", 32'h0, {31'h0, drop});
		pv <= 1'b0;
		ce_i <= 1'b1;
		@(posedge clk_i);
		rd(drop_stats_pkg::IDX_CNT0, 32'h0, "frozen count");
	endtask
	task automatic t_test;
		wr(drop_stats_pkg::IDX_CONFIG, 32'h40);
		pkt(2'd1, drop_stats_pkg::COLOR_GREEN, 8'h00, 1'b1, 1'b1);
		rd(drop_stats_pkg::IDX_CNT1, 32'h1, "test count");
		repeat (4) pkt(2'd1, drop_stats_pkg::COLOR_GREEN, 8'h00, 1'b1, 1'b1);
		rd(drop_stats_pkg::IDX_CNT1, 32'h80000000, "test load");
		wr(drop_stats_pkg::IDX_CONFIG, 32'h0);
		rd(drop_stats_pkg::IDX_CNT1, 32'h7ffffffc, "test reload");
		rd(drop_stats_pkg::IDX_CNT1, 32'h0, "test clear");
	endtask
	initial begin
		do_reset();
		t_start();
		t_counts();
		t_reserved();
		t_table();
		t_usage();
		t_colors();
		t_freeze();
		t_test();
		pkt(2'd2, drop_stats_pkg::COLOR_GREEN, 8'h00, 1'b1, 1'b1);
		do_reset();
		t_start();
		finish_test();
	end
	initial begin
		repeat (20000) @(posedge clk_i);
		num_errors++;
		finish_test();
	end
endmodule
bind switch_buffer_drop_stats drop_stats_asserts #(.INIT_ENTRIES(INIT_ENTRIES)) u_chk (.clk_i(clk_i),
	.rst_i(rst_i), .ce_i(ce_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i),
	.wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
	.pkt_valid_i(pkt_valid_i), .pkt_i(pkt_i), .pkt_done_o(pkt_done_o), .pkt_drop_o(pkt_drop_o),
	.ready_o(ready_o));
